// ===== pkg/sbt_pkg.sv
// shared constants and types for the boundary-scan test port and its controller
package sbt_pkg;

  // ***************************************************************
  // scan register sizes
  // ***************************************************************
  localparam int IR_W = 3;
  localparam int IR_CAP_W = 2;
  localparam logic [IR_CAP_W-1:0] IR_CAPTURE = 2'h1;
  localparam int BSR_LEN = 71;
  localparam int ID_W = 32;
  localparam int LEN_W = 7;

  // ***************************************************************
  // instruction codes
  // ***************************************************************
  localparam logic [IR_W-1:0] OP_CAP_FLOAT = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE_FLOAT = 3'h2;
  localparam logic [IR_W-1:0] OP_RSVD_A = 3'h3;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] OP_RSVD_B = 3'h5;
  localparam logic [IR_W-1:0] OP_RSVD_C = 3'h6;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;

  // ***************************************************************
  // identification word layout
  // ***************************************************************
  localparam int ID_REV_W = 3;
  localparam int ID_PART_W = 17;
  localparam int ID_VEND_W = 11;
  localparam logic ID_PRESENT = 1'b1;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int MCLK_PERIOD_NS = 20;
  localparam int TCK_MIN_PERIOD_NS = 50;
  localparam int TCK_HALF_MIN = (TCK_MIN_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int TDO_SYNC_LAT = 3;
  localparam int RST_TMS_EDGES = 5;

  // ***************************************************************
  // controller commands and mode-select preambles (lsb first)
  // ***************************************************************
  localparam logic [1:0] KIND_RESET = 2'h0;
  localparam logic [1:0] KIND_IR = 2'h1;
  localparam logic [1:0] KIND_DR = 2'h2;
  localparam logic [1:0] KIND_BAD = 2'h3;
  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] PRE_IR = 6'h03;
  localparam logic [PRE_W-1:0] PRE_DR = 6'h01;
  localparam logic [PRE_W-1:0] PRE_RST = 6'h1F;
  localparam int PRE_IR_N = 4;
  localparam int PRE_DR_N = 3;
  localparam int PRE_RST_N = RST_TMS_EDGES + 1;

  typedef enum logic [15:0] {
    ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SDR = 16'h0004, ST_CDR = 16'h0008,
    ST_SHD = 16'h0010, ST_E1D = 16'h0020, ST_PD = 16'h0040, ST_E2D = 16'h0080,
    ST_UDR = 16'h0100, ST_SIR = 16'h0200, ST_CIR = 16'h0400, ST_SHI = 16'h0800,
    ST_E1I = 16'h1000, ST_PI = 16'h2000, ST_E2I = 16'h4000, ST_UIR = 16'h8000
  } sbt_tap_state_e;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_PRE = 5'h02, H_SHIFT = 5'h04, H_POST = 5'h08, H_END = 5'h10
  } sbt_host_state_e;

  function automatic logic sbt_is_reserved(input logic [IR_W-1:0] op);
    sbt_is_reserved = (op == OP_RSVD_A) || (op == OP_RSVD_B) || (op == OP_RSVD_C);
  endfunction

endpackage

// ===== pkg/sbt_link_if.sv
// serial test link between the scan controller and the test port
`timescale 1ns/1ns
`default_nettype none
interface sbt_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
  modport host (output tck, output tms, output tdi, input tdo, input tdo_oe_n);
endinterface
`default_nettype wire

// ===== rtl/sbt_tap_dev.sv
// boundary-scan test access port of the memory device, clocked by the link clock
// What this block does
// R1 - three-bit instruction register, loaded serially from tdi
// R2 - reset and power-up load identification instruction
// R3 - capture-ir loads 01 into low bits
// R4 - one-bit bypass, cleared on capture under bypass
// R5 - boundary register is 71 cells long
// R6 - capture-dr loads ring, shift-dr shifts it out
// R7 - msb takes tdi, lsb drives tdo
// R8 - identification instruction captures hardwired 32-bit word
// R9 - shifted instruction takes effect only at update-ir
// R10 - controller never loads the three reserved codes
// R11 - all-zero code samples and floats memory outputs
// R12 - sample-float code shifts ring, floats outputs
// R13 - sample code snapshots balls without disturbing memory
// R14 - update-dr under sample changes nothing
// R15 - port never drives core or preloads buffers
// R16 - controller passes captured clock cell on as is, even if unstoppable
// R17 - opcode decode: 000,010,100 boundary, 001 identification, rest (reserved and 111) bypass
// R18 - five rising edges with tms high reset
// R19 - inputs on rising edge, tdo on falling edge
// R20 - id word: revision 31:29, vendor 11:1, bit0 one
// R21 - standard sixteen-state controller advanced by tms
`timescale 1ns/1ns
`default_nettype none
module sbt_tap_dev
  import sbt_pkg::*;
#(
  parameter logic [ID_REV_W-1:0] ID_REV = 3'h2,
  parameter logic [ID_PART_W-1:0] ID_PART = 17'h01234,
  parameter logic [ID_VEND_W-1:0] ID_VENDOR = 11'h2A5
) (
  // link
  sbt_link_if.dev lnk,
  // control
  input wire logic i_reset,
  input wire logic i_ce,
  // memory side
  input wire logic [BSR_LEN-1:0] i_ring,
  output logic o_float,
  output logic [IR_W-1:0] o_instr
);

  // id parameter values above are arbitrary, not a real maker's code
  localparam logic [ID_W-1:0] ID_WORD = {ID_REV, ID_PART, ID_VENDOR, ID_PRESENT}; // see R20

  // ***************************************************************
  // decode helpers
  // ***************************************************************
  function automatic logic f_sel_bsr(input logic [IR_W-1:0] op);
    f_sel_bsr = (op == OP_CAP_FLOAT) || (op == OP_SAMPLE_FLOAT) || (op == OP_SAMPLE); // see R17
  endfunction

  function automatic logic f_floats(input logic [IR_W-1:0] op);
    f_floats = (op == OP_CAP_FLOAT) || (op == OP_SAMPLE_FLOAT); // see R11 see R12
  endfunction

  sbt_tap_state_e state_r;
  sbt_tap_state_e state_nxt;
  logic [BSR_LEN-1:0] ring_s1_r;
  logic [BSR_LEN-1:0] ring_s2_r;
  logic [IR_W-1:0] ir_shift_r;
  logic [IR_W-1:0] ir_r;
  logic float_r;
  logic bypass_r;
  logic [ID_W-1:0] id_r;
  logic [BSR_LEN-1:0] bsr_r;
  logic dr_lsb;
  logic tdo_r;
  logic tdo_oe_n_r;

  // ***************************************************************
  // controller state machine
  // ***************************************************************
  always_comb begin
    case (state_r)
      ST_TLR: state_nxt = lnk.tms ? ST_TLR : ST_RTI;
      ST_RTI: state_nxt = lnk.tms ? ST_SDR : ST_RTI;
      ST_SDR: state_nxt = lnk.tms ? ST_SIR : ST_CDR;
      ST_CDR: state_nxt = lnk.tms ? ST_E1D : ST_SHD;
      ST_SHD: state_nxt = lnk.tms ? ST_E1D : ST_SHD;
      ST_E1D: state_nxt = lnk.tms ? ST_UDR : ST_PD;
      ST_PD: state_nxt = lnk.tms ? ST_E2D : ST_PD;
      ST_E2D: state_nxt = lnk.tms ? ST_UDR : ST_SHD;
      ST_UDR: state_nxt = lnk.tms ? ST_SDR : ST_RTI;
      ST_SIR: state_nxt = lnk.tms ? ST_TLR : ST_CIR;
      ST_CIR: state_nxt = lnk.tms ? ST_E1I : ST_SHI;
      ST_SHI: state_nxt = lnk.tms ? ST_E1I : ST_SHI;
      ST_E1I: state_nxt = lnk.tms ? ST_UIR : ST_PI;
      ST_PI: state_nxt = lnk.tms ? ST_E2I : ST_PI;
      ST_E2I: state_nxt = lnk.tms ? ST_UIR : ST_SHI;
      ST_UIR: state_nxt = lnk.tms ? ST_SDR : ST_RTI;
      default: state_nxt = ST_TLR;
    endcase
  end

  // any state reaches reset within five edges of tms high
  always_ff @(posedge lnk.tck or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_TLR;
    end else if (i_ce) begin
      state_r <= state_nxt; // see R21 see R18 see R19
    end
  end

  // ***************************************************************
  // io ring synchroniser
  // ***************************************************************
  // ring runs on the memory clock; a fast edge near capture may still
  // land either way, so a free-running clock cell is unreliable
  always_ff @(posedge lnk.tck or posedge i_reset) begin
    if (i_reset) begin
      ring_s1_r <= '0;
      ring_s2_r <= '0;
    end else if (i_ce) begin
      ring_s1_r <= i_ring;
      ring_s2_r <= ring_s1_r;
    end
  end

  // ***************************************************************
  // instruction register
  // ***************************************************************
  always_ff @(posedge lnk.tck or posedge i_reset) begin
    if (i_reset) begin
      ir_shift_r <= OP_IDCODE;
      ir_r <= OP_IDCODE; // see R2
      float_r <= 1'b0;
    end else if (i_ce) begin
      case (state_r)
        ST_TLR: begin
          ir_r <= OP_IDCODE; // see R2
          float_r <= f_floats(OP_IDCODE);
        end
        ST_CIR: begin
          ir_shift_r <= {{(IR_W - IR_CAP_W){1'b0}}, IR_CAPTURE}; // see R3
        end
        ST_SHI: begin
          ir_shift_r <= {lnk.tdi, ir_shift_r[IR_W-1:1]}; // see R1 see R7
        end
        ST_UIR: begin
          // reserved codes fall through to the bypass path
          ir_r <= ir_shift_r; // see R9 see R10
          float_r <= f_floats(ir_shift_r); // see R11 see R12
        end
        default: begin
          ir_r <= ir_r;
        end
      endcase
    end
  end

  // ***************************************************************
  // data registers
  // ***************************************************************
  // capture only: nothing here ever reaches the core or the buffers
  always_ff @(posedge lnk.tck or posedge i_reset) begin
    if (i_reset) begin
      bsr_r <= '0;
      id_r <= '0;
      bypass_r <= 1'b0;
    end else if (i_ce) begin
      case (state_r)
        ST_CDR: begin
          if (f_sel_bsr(ir_r)) begin
            bsr_r <= ring_s2_r; // see R6 see R13 see R15
          end else if (ir_r == OP_IDCODE) begin
            id_r <= ID_WORD; // see R8
          end else begin
            bypass_r <= 1'b0; // see R4
          end
        end
        ST_SHD: begin
          if (f_sel_bsr(ir_r)) begin
            bsr_r <= {lnk.tdi, bsr_r[BSR_LEN-1:1]}; // see R5 see R7
          end else if (ir_r == OP_IDCODE) begin
            id_r <= {lnk.tdi, id_r[ID_W-1:1]}; // see R8
          end else begin
            bypass_r <= lnk.tdi; // see R4
          end
        end
        default: begin
          // update-dr acts like a pause: no preload into the cells
          bsr_r <= bsr_r; // see R14
        end
      endcase
    end
  end

  always_comb begin
    if (f_sel_bsr(ir_r)) begin
      dr_lsb = bsr_r[0];
    end else if (ir_r == OP_IDCODE) begin
      dr_lsb = id_r[0];
    end else begin
      dr_lsb = bypass_r;
    end
  end

  // ***************************************************************
  // serial output on the falling edge
  // ***************************************************************
  // half a period of hold for the controller sampling on the rise
  always_ff @(negedge lnk.tck or posedge i_reset) begin
    if (i_reset) begin
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else if (i_ce) begin
      case (state_r)
        ST_SHI: begin
          tdo_r <= ir_shift_r[0]; // see R19 see R7
          tdo_oe_n_r <= 1'b0;
        end
        ST_SHD: begin
          tdo_r <= dr_lsb; // see R19 see R7
          tdo_oe_n_r <= 1'b0;
        end
        default: begin
          tdo_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign lnk.tdo = tdo_r;
  assign lnk.tdo_oe_n = tdo_oe_n_r;
  assign o_float = float_r;
  assign o_instr = ir_r;

endmodule
`default_nettype wire

// ===== rtl/sbt_tap_host.sv
// scan controller end: makes the link clock and runs reset, ir and dr scans
`timescale 1ns/1ns
`default_nettype none
module sbt_tap_host
  import sbt_pkg::*;
#(
  // half link period in mclk cycles; at least TCK_HALF_MIN and TDO_SYNC_LAT
  parameter int HALF = 4,
  parameter int DIV_W = 8
) (
  // clock and control
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // command
  input wire logic i_start,
  input wire logic [1:0] i_kind,
  input wire logic [LEN_W-1:0] i_len,
  input wire logic [BSR_LEN-1:0] i_data,
  // answer
  output logic o_busy,
  output logic o_done,
  output logic o_refused,
  output logic [BSR_LEN-1:0] o_data,
  // link
  sbt_link_if.host lnk
);

  sbt_host_state_e st_r;
  logic [DIV_W-1:0] div_r;
  logic tck_r;
  logic tms_r;
  logic tdi_r;
  logic tdo_s1_r;
  logic tdo_s2_r;
  logic init_r;
  logic [1:0] kind_r;
  logic [LEN_W-1:0] len_r;
  logic [LEN_W-1:0] cnt_r;
  logic [PRE_W-1:0] pre_r;
  logic [BSR_LEN-1:0] dat_r;
  logic [BSR_LEN-1:0] rx_r;
  logic samp_r;
  logic busy_r;
  logic done_r;
  logic refused_r;
  logic [BSR_LEN-1:0] data_r;
  logic tick;
  logic rise;
  logic fall;
  logic go;
  logic [1:0] go_kind;
  logic go_bad;
  logic [PRE_W-1:0] go_pre;
  logic [LEN_W-1:0] go_npre;

  // ***************************************************************
  // command check
  // ***************************************************************
  always_comb begin
    go = (st_r == H_IDLE) && (init_r || i_start);
    go_kind = init_r ? KIND_RESET : i_kind;
    go_bad = !init_r && ((i_kind == KIND_BAD)
      || ((i_kind == KIND_DR) && ((i_len == '0) || (i_len > LEN_W'(BSR_LEN))))
      || ((i_kind == KIND_IR) && sbt_is_reserved(i_data[IR_W-1:0]))); // see R10
    case (go_kind)
      KIND_IR: begin
        go_pre = PRE_IR;
        go_npre = LEN_W'(PRE_IR_N);
      end
      KIND_DR: begin
        go_pre = PRE_DR;
        go_npre = LEN_W'(PRE_DR_N);
      end
      default: begin
        go_pre = PRE_RST; // see R18
        go_npre = LEN_W'(PRE_RST_N);
      end
    endcase
  end

  // ***************************************************************
  // link clock divider
  // ***************************************************************
  assign tick = (st_r != H_IDLE) && (div_r == DIV_W'(HALF - 1));
  assign rise = tick && !tck_r;
  assign fall = tick && tck_r;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      div_r <= '0;
      tck_r <= 1'b0;
    end else if (i_ce) begin
      if (st_r == H_IDLE || tick) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
      if (tick) begin
        tck_r <= !tck_r;
      end
    end
  end

  // ***************************************************************
  // tdo synchroniser
  // ***************************************************************
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      tdo_s1_r <= 1'b0;
      tdo_s2_r <= 1'b0;
    end else if (i_ce) begin
      tdo_s1_r <= lnk.tdo;
      tdo_s2_r <= tdo_s1_r;
    end
  end

  // ***************************************************************
  // sequencer: tms and tdi change only while the link clock is low
  // ***************************************************************
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= H_IDLE;
      init_r <= 1'b1;
      tms_r <= 1'b1;
      tdi_r <= 1'b0;
      kind_r <= KIND_RESET;
      len_r <= '0;
      cnt_r <= '0;
      pre_r <= '0;
      dat_r <= '0;
      samp_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (i_ce) begin
      case (st_r)
        H_IDLE: begin
          if (go && !go_bad) begin
            init_r <= 1'b0;
            st_r <= H_PRE;
            busy_r <= 1'b1;
            tms_r <= go_pre[0];
            pre_r <= go_pre >> 1;
            cnt_r <= go_npre - 1'b1;
            kind_r <= go_kind;
            len_r <= (go_kind == KIND_IR) ? LEN_W'(IR_W) : (go_kind == KIND_DR) ? i_len : '0;
            dat_r <= i_data;
          end
        end
        H_PRE: begin
          if (fall) begin
            if (cnt_r != '0) begin
              tms_r <= pre_r[0]; // see R21
              pre_r <= pre_r >> 1;
              cnt_r <= cnt_r - 1'b1;
            end else if (kind_r == KIND_RESET) begin
              st_r <= H_END;
            end else begin
              tms_r <= (len_r == LEN_W'(1));
              tdi_r <= dat_r[0]; // see R1 see R9
              dat_r <= dat_r >> 1;
              samp_r <= 1'b1;
              cnt_r <= len_r - 1'b1;
              st_r <= H_SHIFT;
            end
          end
        end
        H_SHIFT: begin
          if (fall) begin
            if (cnt_r != '0) begin
              tms_r <= (cnt_r == LEN_W'(1));
              tdi_r <= dat_r[0];
              dat_r <= dat_r >> 1;
              cnt_r <= cnt_r - 1'b1;
            end else begin
              tms_r <= 1'b1; // see R9
              tdi_r <= 1'b0;
              samp_r <= 1'b0;
              st_r <= H_POST;
            end
          end
        end
        H_POST: begin
          if (fall) begin
            tms_r <= 1'b0;
            st_r <= H_END;
          end
        end
        H_END: begin
          if (fall) begin
            st_r <= H_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // receive and answer
  // ***************************************************************
  // captured clock cell is passed on as is; the user must judge it
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rx_r <= '0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      data_r <= '0;
    end else if (i_ce) begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
      if (go) begin
        rx_r <= '0;
        done_r <= go_bad;
        refused_r <= go_bad;
      end else if (rise && samp_r) begin
        rx_r <= {tdo_s2_r, rx_r[BSR_LEN-1:1]}; // see R7 see R16
      end
      if (st_r == H_END && fall) begin
        done_r <= 1'b1;
        data_r <= rx_r >> (LEN_W'(BSR_LEN) - len_r);
      end
    end
  end

  assign lnk.tck = tck_r;
  assign lnk.tms = tms_r;
  assign lnk.tdi = tdi_r;
  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_refused = refused_r;
  assign o_data = data_r;

endmodule
`default_nettype wire

// ===== test/sbt_link_props.sv
// concurrent checks on the serial test link between the two ends
`timescale 1ns/1ns
`default_nettype none
module sbt_link_props (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  // ************************
  // edge discipline, sampled on the fast clock
  // ************************
  // the fast clock sees every link edge, so a change seen with tck high is a real slip
  property p_tdo_fall;
    @(posedge i_mclk) disable iff (i_reset) $changed(tdo) |-> !tck;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
  property p_tms_fall;
    @(posedge i_mclk) disable iff (i_reset) ($changed(tms) || $changed(tdi)) |-> !tck;
  endproperty
  a_tms_fall: assert property (p_tms_fall) else $error("tms or tdi moved in tck high");
  property p_oe_fall;
    @(posedge i_mclk) disable iff (i_reset) $changed(tdo_oe_n) |-> !tck;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved in tck high");
  property p_tck_hi;
    @(posedge i_mclk) disable iff (i_reset) $rose(tck) |-> tck[*2];
  endproperty
  a_tck_hi: assert property (p_tck_hi) else $error("tck high phase too short");
  property p_rst_rel;
    @(posedge i_mclk) disable iff (i_reset) $fell(i_reset) |-> tdo_oe_n && !tdo;
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("tdo driven out of reset");
  // ************************
  // state sequencing, sampled on the link clock
  // ************************
  property p_shift_hold;
    @(posedge tck) disable iff (i_reset) !tdo_oe_n && !tms |=> !tdo_oe_n;
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift left with tms low");
  property p_tms_exit;
    @(posedge tck) disable iff (i_reset) tms |=> tdo_oe_n;
  endproperty
  a_tms_exit: assert property (p_tms_exit) else $error("shift held with tms high");
  property p_enter;
    @(posedge tck) disable iff (i_reset) $fell(tdo_oe_n) |-> !$past(tms);
  endproperty
  a_enter: assert property (p_enter) else $error("shift entered with tms high");
  property p_reset5;
    @(posedge tck) disable iff (i_reset) tms[*5] ##1 !tms |=> tdo_oe_n;
  endproperty
  a_reset5: assert property (p_reset5) else $error("five tms highs did not reset");
  c_shift: cover property (@(posedge tck) disable iff (i_reset) $fell(tdo_oe_n));
  c_reset5: cover property (@(posedge tck) disable iff (i_reset) tms[*5]);
  c_tdo_one: cover property (@(posedge i_mclk) disable iff (i_reset) $rose(tdo));
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench: controller end and device end joined by the link
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sbt_pkg::*;
  // ************************
  // signals and ends
  // ************************
  // id fields: arbitrary values
  localparam logic [ID_REV_W-1:0] T_REV = 3'h5;
  localparam logic [ID_PART_W-1:0] T_PART = 17'h0ABCD;
  localparam logic [ID_VEND_W-1:0] T_VEND = 11'h155;
  localparam logic [ID_W-1:0] ID_WORD = {T_REV, T_PART, T_VEND, ID_PRESENT};
  typedef struct packed {
    logic refd;
    logic [BSR_LEN-1:0] data;
    logic [BSR_LEN-1:0] mask;
    logic [IR_W-1:0] instr;
    logic flt;
  } sbt_note_s;
  logic i_mclk = 1'b0;
  logic i_reset;
  logic i_ce = 1'b1;
  logic i_start = 1'b0;
  logic [1:0] i_kind = 2'h0;
  logic [LEN_W-1:0] i_len = 7'h00;
  logic [BSR_LEN-1:0] i_data = '0;
  logic [BSR_LEN-1:0] i_ring = '0;
  logic [BSR_LEN-1:0] o_data;
  logic o_busy;
  logic o_done;
  logic o_refused;
  logic o_float;
  logic [IR_W-1:0] o_instr;
  logic [IR_W-1:0] ci = OP_IDCODE;
  logic [31:0] seed = 32'hAE5CD4F5;
  int failures = 0;
  int n_tests = 0;
  int n_done = 0;
  sbt_note_s notes[$];
  sbt_note_s nt;
  sbt_link_if lnk();
  // small half period keeps the long boundary scans short
  sbt_tap_host #(.HALF(3)) u_sbt_tap_host (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
    .i_start(i_start), .i_kind(i_kind), .i_len(i_len), .i_data(i_data), .o_busy(o_busy),
    .o_done(o_done), .o_refused(o_refused), .o_data(o_data), .lnk(lnk));
  sbt_tap_dev #(.ID_REV(T_REV), .ID_PART(T_PART), .ID_VENDOR(T_VEND)) u_sbt_tap_dev (
    .lnk(lnk), .i_reset(i_reset), .i_ce(i_ce), .i_ring(i_ring), .o_float(o_float),
    .o_instr(o_instr));
  sbt_link_props u_sbt_link_props (.i_mclk(i_mclk), .i_reset(i_reset), .tck(lnk.tck),
    .tms(lnk.tms), .tdi(lnk.tdi), .tdo(lnk.tdo), .tdo_oe_n(lnk.tdo_oe_n));
  initial begin
    forever #10 i_mclk = ~i_mclk;
  end
  // ************************
  // helpers
  // ************************
  function automatic void rnd(output logic [BSR_LEN-1:0] r);
    r = '0;
    repeat (3) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      r = {r[BSR_LEN-33:0], seed};
    end
  endfunction
  function automatic logic [BSR_LEN-1:0] ones(input int n);
    return {BSR_LEN{1'b1}} >> (BSR_LEN - n);
  endfunction
  function automatic sbt_note_s note(input logic r, input logic [BSR_LEN-1:0] d, m);
    sbt_note_s n;
    n.refd = r;
    n.data = d;
    n.mask = m;
    n.instr = ci;
    n.flt = (ci == OP_CAP_FLOAT) || (ci == OP_SAMPLE_FLOAT);
    return n;
  endfunction
  task automatic chk(input string what, input logic [BSR_LEN-1:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_done(input int t);
    for (int w = 0; w < 1000 && n_done == t; w++) begin
      @(negedge i_mclk);
    end
    if (n_done == t) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic run(input logic [1:0] k, input int len, input logic [BSR_LEN-1:0] d,
      input sbt_note_s n);
    int t;
    t = n_done;
    notes.push_back(n);
    @(negedge i_mclk);
    i_start = 1'b1;
    i_kind = k;
    i_len = LEN_W'(len);
    i_data = d;
    @(negedge i_mclk);
    i_start = 1'b0;
    chk("o_busy", BSR_LEN'(!n.refd), BSR_LEN'(o_busy));
    wait_done(t);
  endtask
  task automatic ir(input logic [IR_W-1:0] c);
    logic r;
    r = (c == OP_RSVD_A) || (c == OP_RSVD_B) || (c == OP_RSVD_C);
    if (!r) begin
      ci = c;
    end
    run(KIND_IR, IR_W, BSR_LEN'(c), note(r, BSR_LEN'(3'h1), r ? '0 : ones(IR_W)));
  endtask
  task automatic dr(input int len, input logic [BSR_LEN-1:0] d, exp);
    run(KIND_DR, len, d, note(1'b0, exp, ones(len)));
  endtask
  // ************************
  // result watcher
  // ************************
  // read half a cycle after the edge that launches the answer
  always @(negedge i_mclk) begin
    if (o_done === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected done", '0, '1);
      end else begin
        nt = notes.pop_front();
        chk("o_data", nt.data & nt.mask, o_data & nt.mask);
        chk("o_refused", BSR_LEN'(nt.refd), BSR_LEN'(o_refused));
        chk("o_instr", BSR_LEN'(nt.instr), BSR_LEN'(o_instr));
        chk("o_float", BSR_LEN'(nt.flt), BSR_LEN'(o_float));
      end
      n_done++;
    end
  end
  // ************************
  // scenarios
  // ************************
  initial begin
    logic [BSR_LEN-1:0] d;
    logic [IR_W-1:0] c;
    // raised here so the tck-clocked resets see a real edge
    i_reset = 1'b1;
    notes.push_back(note(1'b0, '0, ones(BSR_LEN)));
    repeat (2) @(negedge i_mclk);
    i_reset = 1'b0;
    wait_done(0);
    $display("test power-up done");
    rnd(d);
    dr(ID_W + 1, d, BSR_LEN'({d[0], ID_WORD}));
    $display("test id word done");
    // every code, reserved ones included, so refusal and decode are both hit
    for (int i = 0; i < 8; i++) begin
      c = IR_W'(i);
      rnd(i_ring);
      ir(c);
      rnd(d);
      if (c == OP_BYPASS) begin
        dr(2, d, BSR_LEN'({d[0], 1'b0}));
      end else if (c == OP_IDCODE) begin
        dr(ID_W, d, BSR_LEN'(ID_WORD));
      end else if (ci == c) begin
        dr(BSR_LEN, d, i_ring);
        dr(8, d, i_ring);
      end
    end
    $display("test codes done");
    run(KIND_BAD, 1, '0, note(1'b1, '0, '0));
    run(KIND_DR, 0, '0, note(1'b1, '0, '0));
    run(KIND_DR, BSR_LEN + 1, '0, note(1'b1, '0, '0));
    $display("test refusals done");
    ir(OP_BYPASS);
    ci = OP_IDCODE;
    run(KIND_RESET, 0, '0, note(1'b0, '0, ones(BSR_LEN)));
    rnd(d);
    dr(ID_W, d, BSR_LEN'(ID_WORD));
    $display("test link reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
